/* pes_defs.svh */
// Offsets, reset values and field masks of the event and status bank
`ifndef PES_DEFS_SVH
`define PES_DEFS_SVH
// Identification registers
`define PES_ADDR_DEV_ID      8'h00
`define PES_ADDR_SI_REV      8'h01
`define PES_ADDR_FUSE_UPPER  8'h02
`define PES_ADDR_FUSE_LOWER  8'h03
// Event groups: latch, mask, live; buck mode group has latch and mask only
`define PES_ADDR_SYS_LATCH   8'h04
`define PES_ADDR_SYS_MASK    8'h05
`define PES_ADDR_SYS_LIVE    8'h06
`define PES_ADDR_THW_LATCH   8'h07
`define PES_ADDR_THW_MASK    8'h80
`define PES_ADDR_THW_LIVE    8'h09
`define PES_ADDR_BMODE_LATCH 8'h0a
`define PES_ADDR_BMODE_MASK  8'h0b
`define PES_ADDR_BILIM_LATCH 8'h0c
`define PES_ADDR_BILIM_MASK  8'h0d
`define PES_ADDR_BILIM_LIVE  8'h0e
`define PES_ADDR_LILIM_LATCH 8'h0f
`define PES_ADDR_LILIM_MASK  8'h10
`define PES_ADDR_LILIM_LIVE  8'h11
`define PES_ADDR_BUV_LATCH   8'h12
`define PES_ADDR_BUV_MASK    8'h13
`define PES_ADDR_BUV_LIVE    8'h14
`define PES_ADDR_BOV_LATCH   8'h15
`define PES_ADDR_BOV_MASK    8'h16
`define PES_ADDR_BOV_LIVE    8'h17
`define PES_ADDR_LUV_LATCH   8'h18
`define PES_ADDR_LUV_MASK    8'h19
`define PES_ADDR_LUV_LIVE    8'h1a
`define PES_ADDR_LOV_LATCH   8'h1b
`define PES_ADDR_LOV_MASK    8'h1c
`define PES_ADDR_LOV_LIVE    8'h1d
`define PES_ADDR_PWR_LATCH   8'h1e
`define PES_ADDR_PWR_MASK    8'h1f
`define PES_ADDR_PWR_LIVE    8'h20
// Status, fault and self-test registers
`define PES_ADDR_EN_LEVELS   8'h21
`define PES_ADDR_SUMMARY     8'h22
`define PES_ADDR_HARD_FAULT  8'h23
`define PES_ADDR_ST_PGOOD    8'h25
`define PES_ADDR_ST_OV1      8'h26
`define PES_ADDR_ST_OV2      8'h27
// Mask reset values
`define PES_MRST_SYS         8'hfb
`define PES_MRST_THW         8'hff
`define PES_MRST_BUCK        8'h4f
`define PES_MRST_LDO         8'h01
`define PES_MRST_PWR         8'hff
// Defined event bits per group kind
`define PES_DEF_SYS          8'hfb
`define PES_DEF_THW          8'hff
`define PES_DEF_BUCK         8'h43
`define PES_DEF_LDO          8'h01
`define PES_DEF_PWR          8'hff
// Bits that carry a live level
`define PES_LIVE_SYS         8'h03
`define PES_LIVE_PWR         8'h81
// Other field masks and reset values
`define PES_DEF_HARD_FAULT   8'h0f
`define PES_DEF_ST_OV1       8'h43
`define PES_DEF_SINGLE       8'h01
`define PES_LATCH_RST        8'h00
`endif

/* pes_pkg.sv */
// Types shared by the event and status bank
`default_nettype none
package pes_pkg;
   typedef logic [7:0] pes_byte_t;
   // Register access classes, one-hot
   typedef enum logic [4:0] {
      PES_ACC_NONE = 5'b00001,
      PES_ACC_RO   = 5'b00010,
      PES_ACC_RW   = 5'b00100,
      PES_ACC_W1C  = 5'b01000,
      PES_ACC_SW   = 5'b10000
   } pes_acc_t;
endpackage : pes_pkg
`default_nettype wire

/* pes_event_bank.sv */
// Event latch, mask, live and status register bank with interrupt output
`include "pes_defs.svh"
`default_nettype none
module pes_event_bank #(
   parameter logic [3:0] DEV_FAMILY = 4'ha,  // Arbitrary value
   parameter logic [3:0] DEV_VARIANT = 4'h3, // Arbitrary value
   parameter logic [7:0] SI_REVISION = 8'h11, // Arbitrary value
   parameter logic [2:0] FUSE_MAP_REV = 3'h1  // Arbitrary value
) (
   input  wire logic            core_clk_in,        // Core clock
   input  wire logic            reset_in,           // Sync reset, high
   input  wire logic            ce_in,              // Clock enable
   input  wire logic [7:0]      reg_addr_in,        // Register offset
   input  wire pes_pkg::pes_byte_t reg_wdata_in,    // Write data
   input  wire logic            reg_wr_in,          // Write strobe
   input  wire logic            reg_rd_in,          // Read strobe
   input  wire logic            reg_secure_in,      // Secure write qualifier
   output var  pes_pkg::pes_byte_t reg_rdata_out,   // Read data
   output var  logic            reg_rvalid_out,     // Read data valid
   input  wire logic [7:0]      sys_level_in,       // System conditions
   input  wire logic [7:0]      thermal_level_in,   // Thermal, watchdog
   input  wire logic [7:0]      buck_mode_level_in, // Buck mode states
   input  wire logic [7:0]      buck_ilim_level_in, // Buck current limit
   input  wire logic [7:0]      ldo_ilim_level_in,  // Linear current limit
   input  wire logic [7:0]      buck_uv_level_in,   // Buck undervoltage
   input  wire logic [7:0]      buck_ov_level_in,   // Buck overvoltage
   input  wire logic [7:0]      ldo_uv_level_in,    // Linear undervoltage
   input  wire logic [7:0]      ldo_ov_level_in,    // Linear overvoltage
   input  wire logic [7:0]      pwron_level_in,     // Power button timing
   input  wire logic [3:0]      enable_pin_in,      // Enable pin levels
   input  wire logic [3:0]      hard_fault_in,      // Hard fault pulses
   input  wire logic            input_undervoltage_threshold_in, // UV cross
   input  wire logic            off_entry_in,       // Off state entered
   input  wire logic            main_below_in,      // Main input below UV
   input  wire logic            backup_rail_in,     // Backup rail present
   input  wire logic            fuse_load_in,       // Fuse load pulse
   input  wire logic [11:0]     fuse_fuse_program_lower_in,    // Fuse program word
   output var  logic            int_n_out           // Interrupt, low active
);
   import pes_pkg::*;

   localparam int NGRP = 10;

   pes_byte_t level   [NGRP];
   pes_byte_t level_q [NGRP];
   pes_byte_t latch   [NGRP];
   pes_byte_t mask    [NGRP];
   logic [NGRP-1:0] pending;
   pes_byte_t hard_fault;
   pes_byte_t st_pgood;
   pes_byte_t st_ov1;
   pes_byte_t st_ov2;
   logic [11:0] fuse_program_lower;
   logic [3:0]  en_q;
   pes_byte_t summary;
   pes_byte_t next_rdata;
   logic      uv_rst;
   logic      off_rst;
   logic      backup_rst;
   logic      wr_go;
   pes_acc_t  wr_class;

   // Group address and field tables
   function automatic pes_byte_t latch_addr(input int g);
      case (g)
         0: latch_addr = `PES_ADDR_SYS_LATCH;
         1: latch_addr = `PES_ADDR_THW_LATCH;
         2: latch_addr = `PES_ADDR_BMODE_LATCH;
         3: latch_addr = `PES_ADDR_BILIM_LATCH;
         4: latch_addr = `PES_ADDR_LILIM_LATCH;
         5: latch_addr = `PES_ADDR_BUV_LATCH;
         6: latch_addr = `PES_ADDR_BOV_LATCH;
         7: latch_addr = `PES_ADDR_LUV_LATCH;
         8: latch_addr = `PES_ADDR_LOV_LATCH;
         default: latch_addr = `PES_ADDR_PWR_LATCH;
      endcase
   endfunction : latch_addr

   function automatic pes_byte_t mask_addr(input int g);
      case (g)
         0: mask_addr = `PES_ADDR_SYS_MASK;
         1: mask_addr = `PES_ADDR_THW_MASK;
         2: mask_addr = `PES_ADDR_BMODE_MASK;
         3: mask_addr = `PES_ADDR_BILIM_MASK;
         4: mask_addr = `PES_ADDR_LILIM_MASK;
         5: mask_addr = `PES_ADDR_BUV_MASK;
         6: mask_addr = `PES_ADDR_BOV_MASK;
         7: mask_addr = `PES_ADDR_LUV_MASK;
         8: mask_addr = `PES_ADDR_LOV_MASK;
         default: mask_addr = `PES_ADDR_PWR_MASK;
      endcase
   endfunction : mask_addr

   // Buck mode group has no live register; it never matches
   function automatic logic live_hit(input int g, input pes_byte_t a);
      case (g)
         0: live_hit = (a == `PES_ADDR_SYS_LIVE);
         1: live_hit = (a == `PES_ADDR_THW_LIVE);
         3: live_hit = (a == `PES_ADDR_BILIM_LIVE);
         4: live_hit = (a == `PES_ADDR_LILIM_LIVE);
         5: live_hit = (a == `PES_ADDR_BUV_LIVE);
         6: live_hit = (a == `PES_ADDR_BOV_LIVE);
         7: live_hit = (a == `PES_ADDR_LUV_LIVE);
         8: live_hit = (a == `PES_ADDR_LOV_LIVE);
         9: live_hit = (a == `PES_ADDR_PWR_LIVE);
         default: live_hit = 1'b0;
      endcase
   endfunction : live_hit

   function automatic pes_byte_t def_bits(input int g);
      case (g)
         0: def_bits = `PES_DEF_SYS;
         1: def_bits = `PES_DEF_THW;
         2, 3, 5, 6: def_bits = `PES_DEF_BUCK;
         4, 7, 8: def_bits = `PES_DEF_LDO;
         default: def_bits = `PES_DEF_PWR;
      endcase
   endfunction : def_bits

   function automatic pes_byte_t live_bits(input int g);
      case (g)
         0: live_bits = `PES_LIVE_SYS;
         9: live_bits = `PES_LIVE_PWR;
         default: live_bits = def_bits(g);
      endcase
   endfunction : live_bits

   function automatic pes_byte_t mask_rst(input int g);
      case (g)
         0: mask_rst = `PES_MRST_SYS;
         1: mask_rst = `PES_MRST_THW;
         2, 3, 5, 6: mask_rst = `PES_MRST_BUCK;
         4, 7, 8: mask_rst = `PES_MRST_LDO;
         default: mask_rst = `PES_MRST_PWR;
      endcase
   endfunction : mask_rst

   // Access class of each offset
   function automatic pes_acc_t acc_class(input pes_byte_t a);
      acc_class = PES_ACC_NONE;
      if (a <= `PES_ADDR_FUSE_LOWER || a == `PES_ADDR_EN_LEVELS ||
          a == `PES_ADDR_SUMMARY) begin
         acc_class = PES_ACC_RO;
      end
      if (a == `PES_ADDR_HARD_FAULT) begin
         acc_class = PES_ACC_W1C;
      end
      if (a == `PES_ADDR_ST_PGOOD || a == `PES_ADDR_ST_OV1 ||
          a == `PES_ADDR_ST_OV2) begin
         acc_class = PES_ACC_SW;
      end
      for (int g = 0; g < NGRP; g++) begin
         if (a == latch_addr(g)) acc_class = PES_ACC_W1C;
         if (a == mask_addr(g)) acc_class = PES_ACC_RW;
         if (live_hit(g, a)) acc_class = PES_ACC_RO;
      end
   endfunction : acc_class

   // Condition inputs gathered per group
   assign level[0] = sys_level_in;
   assign level[1] = thermal_level_in;
   assign level[2] = buck_mode_level_in;
   assign level[3] = buck_ilim_level_in;
   assign level[4] = ldo_ilim_level_in;
   assign level[5] = buck_uv_level_in;
   assign level[6] = buck_ov_level_in;
   assign level[7] = ldo_uv_level_in;
   assign level[8] = ldo_ov_level_in;
   assign level[9] = pwron_level_in;

   // Reset domains and write qualification
   assign uv_rst     = reset_in | input_undervoltage_threshold_in;
   assign off_rst    = uv_rst | off_entry_in;
   assign backup_rst = reset_in | (main_below_in & ~backup_rail_in);
   assign wr_go      = ce_in & reg_wr_in;
   assign wr_class   = acc_class(reg_addr_in);

   // Live level samples
   always_ff @(posedge core_clk_in) begin
      for (int g = 0; g < NGRP; g++) begin
         if (reset_in) begin
            level_q[g] <= `PES_LATCH_RST;
         end else if (ce_in) begin
            level_q[g] <= level[g] & live_bits(g);
         end
      end
   end

   // Event latches: rising edge of a live bit sets, other defined bits set while high, written one clears, set wins
   always_ff @(posedge core_clk_in) begin
      for (int g = 0; g < NGRP; g++) begin
         if (off_rst) begin
            latch[g] <= `PES_LATCH_RST;
         end else if (ce_in) begin
            latch[g] <= (latch[g] & ~((wr_go && reg_addr_in == latch_addr(g))
                        ? reg_wdata_in : 8'h00))
                        | (level[g] & ~level_q[g] & def_bits(g));
         end
      end
   end

   // Mask registers, plain read and write
   always_ff @(posedge core_clk_in) begin
      for (int g = 0; g < NGRP; g++) begin
         if (off_rst) begin
            mask[g] <= mask_rst(g);
         end else if (wr_go && reg_addr_in == mask_addr(g)) begin
            mask[g] <= reg_wdata_in & (def_bits(g) | mask_rst(g));
         end
      end
   end

   // Unmasked pending events per group
   always_comb begin
      for (int g = 0; g < NGRP; g++) begin
         pending[g] = |(latch[g] & ~mask[g] & def_bits(g));
      end
   end

   // Hard fault flags survive off, cleared by backup loss
   always_ff @(posedge core_clk_in) begin
      if (backup_rst) begin
         hard_fault <= `PES_LATCH_RST;
      end else if (ce_in) begin
         hard_fault <= (hard_fault & ~((wr_go &&
                       reg_addr_in == `PES_ADDR_HARD_FAULT) ?
                       reg_wdata_in : 8'h00))
                       | ({4'h0, hard_fault_in} & `PES_DEF_HARD_FAULT);
      end
   end

   // Self-test results, secure write only
   always_ff @(posedge core_clk_in) begin
      if (uv_rst) begin
         st_pgood <= `PES_LATCH_RST;
         st_ov1   <= `PES_LATCH_RST;
         st_ov2   <= `PES_LATCH_RST;
      end else if (wr_go && reg_secure_in && wr_class == PES_ACC_SW) begin
         case (reg_addr_in)
            `PES_ADDR_ST_PGOOD: st_pgood <= reg_wdata_in & `PES_DEF_SINGLE;
            `PES_ADDR_ST_OV1:   st_ov1   <= reg_wdata_in & `PES_DEF_ST_OV1;
            default:            st_ov2   <= reg_wdata_in & `PES_DEF_SINGLE;
         endcase
      end
   end

   // Fuse mirror of the program identifier
   always_ff @(posedge core_clk_in) begin
      if (reset_in || (ce_in && fuse_load_in)) begin
         fuse_program_lower <= fuse_fuse_program_lower_in;
      end
   end

   // Enable pin levels
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         en_q <= 4'h0;
      end else if (ce_in) begin
         en_q <= enable_pin_in;
      end
   end

   // Group summary follows unmasked latched bits
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         summary <= `PES_LATCH_RST;
      end else if (ce_in) begin
         summary <= {(|hard_fault), pending[9], pending[6] | pending[8],
                     pending[5] | pending[7], pending[3] | pending[4],
                     pending[2], pending[1], pending[0]};
      end
   end

   // Interrupt output, low while any unmasked event is held
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         int_n_out <= 1'b1;
      end else if (ce_in) begin
         int_n_out <= ~((|pending) | (|hard_fault));
      end
   end

   // Read multiplexer
   always_comb begin
      next_rdata = 8'h00;
      case (reg_addr_in)
         `PES_ADDR_DEV_ID:     next_rdata = {DEV_FAMILY, DEV_VARIANT};
         `PES_ADDR_SI_REV:     next_rdata = SI_REVISION;
         `PES_ADDR_FUSE_UPPER: next_rdata = {fuse_program_lower[11:8], 1'b0,
                                             FUSE_MAP_REV};
         `PES_ADDR_FUSE_LOWER: next_rdata = fuse_program_lower[7:0];
         `PES_ADDR_EN_LEVELS:  next_rdata = {4'h0, en_q};
         `PES_ADDR_SUMMARY:    next_rdata = summary;
         `PES_ADDR_HARD_FAULT: next_rdata = hard_fault;
         `PES_ADDR_ST_PGOOD:   next_rdata = st_pgood;
         `PES_ADDR_ST_OV1:     next_rdata = st_ov1;
         `PES_ADDR_ST_OV2:     next_rdata = st_ov2;
         default: begin
            for (int g = 0; g < NGRP; g++) begin
               if (reg_addr_in == latch_addr(g)) next_rdata = latch[g];
               if (reg_addr_in == mask_addr(g)) next_rdata = mask[g];
               if (live_hit(g, reg_addr_in)) next_rdata = level_q[g];
            end
         end
      endcase
   end

   // Registered read answer
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         reg_rdata_out  <= 8'h00;
         reg_rvalid_out <= 1'b0;
      end else if (ce_in) begin
         reg_rvalid_out <= reg_rd_in;
         if (reg_rd_in) begin
            reg_rdata_out <= next_rdata;
         end
      end
   end

   // Checks
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (reset_in);

   sequence s_quiet;
      ce_in && !off_rst && !input_undervoltage_threshold_in;
   endsequence

   sequence s_clear_sys;
      s_quiet and (wr_go && reg_addr_in == `PES_ADDR_SYS_LATCH &&
      reg_wdata_in[0] && !(level[0][0] && !level_q[0][0]));
   endsequence

   sequence s_plain_st_wr;
      wr_go && !reg_secure_in && reg_addr_in == `PES_ADDR_ST_OV1 &&
      !uv_rst;
   endsequence

   chk_w1c_clear_bit: assert property (
      s_clear_sys |=> latch[0][0] == 1'b0)
      else $error("written one did not clear latch bit");

   chk_w1c_zero_keeps: assert property (
      (s_quiet and (wr_go && reg_addr_in == `PES_ADDR_SYS_LATCH &&
       !reg_wdata_in[1] && latch[0][1])) |=> latch[0][1])
      else $error("written zero changed latch bit");

   chk_secure_block: assert property (
      s_plain_st_wr |=> $stable(st_ov1))
      else $error("plain write altered secure register");

   chk_fuse_mirror: assert property (
      (ce_in && fuse_load_in) |=> fuse_program_lower == $past(fuse_fuse_program_lower_in))
      else $error("fuse mirror not loaded");

   chk_uv_default: assert property (
      input_undervoltage_threshold_in |=> st_ov1 == 8'h00 &&
      mask[5] == `PES_MRST_BUCK)
      else $error("undervoltage reset did not restore defaults");

   chk_off_default: assert property (
      off_entry_in |=> latch[9] == 8'h00 && mask[0] == `PES_MRST_SYS)
      else $error("off entry did not restore defaults");

   chk_backup_reset: assert property (
      (main_below_in && !backup_rail_in) |=> hard_fault == 8'h00)
      else $error("backup loss did not clear fault flags");

   chk_fault_kept_off: assert property (
      (off_entry_in && !main_below_in && hard_fault[0] &&
       !wr_go) |=> hard_fault[0])
      else $error("fault flag lost on off entry");

   chk_edge_latches: assert property (
      (ce_in && !off_rst && level[1][0] && !level_q[1][0])
      |=> latch[1][0])
      else $error("event edge not latched");

   chk_irq_follows: assert property (
      (ce_in && pending[4] && !off_rst) |=> !int_n_out)
      else $error("interrupt not raised for unmasked event");

   chk_summary_group: assert property (
      ce_in |=> summary[3] == $past(pending[3] | pending[4]))
      else $error("summary bit does not follow its group");

   chk_read_answer: assert property (
      ce_in |=> reg_rvalid_out == $past(reg_rd_in))
      else $error("read answer timing wrong");

endmodule : pes_event_bank
`default_nettype wire

/* pes_host_model.sv */
// Host side model driving the register access port of the event bank
`default_nettype none
module pes_host_model (
   input  wire logic       clk_in,    // Core clock
   output var  logic       ce_out,    // Clock enable
   output var  logic [7:0] addr_out,  // Register offset
   output var  logic [7:0] wdata_out, // Write data
   output var  logic       wr_out,    // Write strobe
   output var  logic       rd_out,    // Read strobe
   output var  logic       sec_out,   // Secure write qualifier
   input  wire logic [7:0] rdata_in,  // Read data
   input  wire logic       rvalid_in  // Read data valid
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle bus from time zero
   initial begin
      ce_out    = 1'b1;
      addr_out  = 8'h00;
      wdata_out = 8'h00;
      wr_out    = 1'b0;
      rd_out    = 1'b0;
      sec_out   = 1'b0;
   end

   // One write strobe, secure flag only when asked
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d,
                            input logic s);
      @(negedge clk_in);
      addr_out  = a;
      wdata_out = d;
      sec_out   = s;
      wr_out    = 1'b1;
      @(negedge clk_in);
      wr_out    = 1'b0;
      sec_out   = 1'b0;
      wdata_out = ~d;
      addr_out  = ~a;
   endtask : write_reg

   // Clock enable level, changed at the falling edge
   task automatic set_ce(input logic v);
      @(negedge clk_in);
      ce_out = v;
   endtask : set_ce

   // One read strobe, then a bounded wait for valid
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      int n;
      @(negedge clk_in);
      addr_out = a;
      rd_out   = 1'b1;
      @(negedge clk_in);
      rd_out   = 1'b0;
      addr_out = ~a;
      n = 0;
      while (rvalid_in !== 1'b1 && n < 3) begin
         @(negedge clk_in);
         n++;
      end
      d = (rvalid_in === 1'b1) ? rdata_in : 8'hxx;
   endtask : read_reg
endmodule : pes_host_model
`default_nettype wire

/* tb.sv */
// Self-checking bench for the event and status bank
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk, reset, ce, wr, rd, sec, rvalid, int_n, fld;
   logic        uv, off, main_below, backup;
   logic [7:0]  addr, wdata, rdata, rv;
   logic [7:0]  lv [10];
   logic [3:0]  en_pin, hf;
   logic [11:0] prog;
   int          n_mismatch = 0;
   int          cmp_count  = 0;
   // Per group: latch, mask and live offsets, mask default, summary bit
   localparam logic [7:0] LA [10] = '{8'h04, 8'h07, 8'h0a, 8'h0c, 8'h0f,
      8'h12, 8'h15, 8'h18, 8'h1b, 8'h1e};
   localparam logic [7:0] MA [10] = '{8'h05, 8'h80, 8'h0b, 8'h0d, 8'h10,
      8'h13, 8'h16, 8'h19, 8'h1c, 8'h1f};
   localparam logic [7:0] LI [10] = '{8'h06, 8'h09, 8'h00, 8'h0e, 8'h11,
      8'h14, 8'h17, 8'h1a, 8'h1d, 8'h20};
   localparam logic [7:0] MD [10] = '{8'hfb, 8'hff, 8'h4f, 8'h4f, 8'h01,
      8'h4f, 8'h4f, 8'h01, 8'h01, 8'hff};
   localparam int SB [10] = '{0, 1, 2, 3, 3, 4, 5, 4, 5, 6};

   pes_host_model pes_host_model_inst (.clk_in(core_clk), .ce_out(ce),
      .addr_out(addr), .wdata_out(wdata), .wr_out(wr), .rd_out(rd),
      .sec_out(sec), .rdata_in(rdata), .rvalid_in(rvalid));

   pes_event_bank pes_event_bank_inst (.core_clk_in(core_clk),
      .reset_in(reset), .ce_in(ce), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_secure_in(sec), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
      .sys_level_in(lv[0]), .thermal_level_in(lv[1]),
      .buck_mode_level_in(lv[2]), .buck_ilim_level_in(lv[3]),
      .ldo_ilim_level_in(lv[4]), .buck_uv_level_in(lv[5]),
      .buck_ov_level_in(lv[6]), .ldo_uv_level_in(lv[7]),
      .ldo_ov_level_in(lv[8]), .pwron_level_in(lv[9]),
      .enable_pin_in(en_pin), .hard_fault_in(hf),
      .input_undervoltage_threshold_in(uv), .off_entry_in(off),
      .main_below_in(main_below), .backup_rail_in(backup),
      .fuse_load_in(fld), .fuse_fuse_program_lower_in(prog), .int_n_out(int_n));

   // Clock at 250 MHz
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   // Compare and count
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   // Read a register and compare
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      pes_host_model_inst.read_reg(a, d);
      check(d, exp);
   endtask : rchk

   // Plain or secure write
   task automatic wr_r(input logic [7:0] a, input logic [7:0] d,
                       input logic s);
      pes_host_model_inst.write_reg(a, d, s);
   endtask : wr_r

   // Let a few edges pass so latches, summary and interrupt settle
   task automatic settle;
      repeat (3) @(negedge core_clk);
   endtask : settle

   // Verdict and end of run
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : wrap_up

   // Watchdog well beyond the expected run length
   initial begin
      #50us;
      n_mismatch++;
      wrap_up();
   end

   // Main sequence
   initial begin
      reset = 1'b1;
      {uv, off, main_below, fld, hf} = '0;
      backup = 1'b1;
      prog   = 12'h5a3;
      en_pin = 4'h9;
      foreach (lv[i]) lv[i] = 8'h00;
      repeat (3) @(negedge core_clk);
      reset = 1'b0;
      // Reset values of all groups and status registers
      for (int g = 0; g < 10; g++) begin
         rchk(LA[g], 8'h00);
         rchk(MA[g], MD[g]);
      end
      for (int a = 8'h22; a < 8'h28; a++) rchk(8'(a), 8'h00);
      check({7'h00, int_n}, 8'h01);
      rchk(8'h03, 8'ha3);
      pes_host_model_inst.read_reg(8'h02, rv);
      check(rv & 8'hf0, 8'h50);
      rchk(8'h21, 8'h09);
      // Fuse reload, and a write to a read-only place
      prog = 12'h3c6;
      @(negedge core_clk) fld = 1'b1;
      @(negedge core_clk) fld = 1'b0;
      wr_r(8'h03, 8'h00, 1'b1);
      rchk(8'h03, 8'hc6);
      // Every group: latch, live where the group has one, masking, summary and clearing
      for (int g = 0; g < 10; g++) begin
         lv[g] = 8'h01;
         settle();
         rchk(LA[g], 8'h01);
         if (LI[g] != 8'h00) rchk(LI[g], 8'h01);
         rchk(8'h22, 8'h00);
         check({7'h00, int_n}, 8'h01);
         wr_r(LA[g], 8'h00, 1'b0);
         rchk(LA[g], 8'h01);
         wr_r(MA[g], MD[g] & 8'hfe, 1'b0);
         settle();
         rchk(8'h22, 8'h01 << SB[g]);
         check({7'h00, int_n}, 8'h00);
         wr_r(LA[g], 8'h01, 1'b0);
         settle();
         rchk(LA[g], 8'h00);
         rchk(8'h22, 8'h00);
         check({7'h00, int_n}, 8'h01);
         lv[g] = 8'h00;
         wr_r(MA[g], MD[g], 1'b0);
      end
      // Secure write class
      wr_r(8'h25, 8'h01, 1'b0);
      rchk(8'h25, 8'h00);
      wr_r(8'h25, 8'h01, 1'b1);
      wr_r(8'h26, 8'h43, 1'b1);
      rchk(8'h25, 8'h01);
      rchk(8'h26, 8'h43);
      // Plain write, then a secure write with the clock enable low
      wr_r(8'h26, 8'h00, 1'b0);
      pes_host_model_inst.set_ce(1'b0);
      wr_r(8'h26, 8'h00, 1'b1);
      pes_host_model_inst.set_ce(1'b1);
      rchk(8'h26, 8'h43);
      // Off entry clears latches and restores mask defaults, keeps results and faults
      wr_r(8'h05, 8'h00, 1'b0);
      lv[0] = 8'h02;
      hf = 4'h5;
      settle();
      hf = 4'h0;
      wr_r(8'h04, 8'h01, 1'b0);
      rchk(8'h04, 8'h02);
      @(negedge core_clk) off = 1'b1;
      @(negedge core_clk) off = 1'b0;
      rchk(8'h04, 8'h00);
      rchk(8'h05, 8'hfb);
      rchk(8'h25, 8'h01);
      rchk(8'h23, 8'h05);
      // Undervoltage crossing also clears self-test results
      wr_r(8'h05, 8'h00, 1'b0);
      lv[0] = 8'h00;
      settle();
      @(negedge core_clk) uv = 1'b1;
      @(negedge core_clk) uv = 1'b0;
      rchk(8'h05, 8'hfb);
      rchk(8'h25, 8'h00);
      rchk(8'h26, 8'h00);
      // Hard faults survive off and UV, clear on write one or backup loss
      rchk(8'h23, 8'h05);
      rchk(8'h22, 8'h80);
      check({7'h00, int_n}, 8'h00);
      wr_r(8'h23, 8'h01, 1'b0);
      rchk(8'h23, 8'h04);
      main_below = 1'b1;
      settle();
      rchk(8'h23, 8'h04);
      backup = 1'b0;
      settle();
      main_below = 1'b0;
      backup = 1'b1;
      rchk(8'h23, 8'h00);
      settle();
      check({7'h00, int_n}, 8'h01);
      wrap_up();
   end
endmodule : tb
`default_nettype wire
